// >>> design/pap_defines.vh
/*
 * Constants for the peripheral auto-powerdown controller: APB register
 * offsets, field positions, reset values and timer counts.
 * Assumes a 100 MHz clock; included from pap_ctrl.v and from the testbench.
 */
// Notes on behaviour
// - floppy auto powerdown only while auto config bit 0 is set.
// - floppy sleeps only with motors off, status 80H, interrupt low.
// - floppy entry also needs head unload expired and 10 ms timer done.
// - timer starts when enabled; powerdown when all conditions hold.
// - clearing the floppy enable cancels timer and blocks auto powerdown.
// - rate-select powerdown overrides auto; auto applies again after it.
// - reset wakes via reset sequence; register access wakes state intact.
// - wake on motor bit write, main status read, data port access.
// - other output/rate writes never wake; output register read never.
// - after any wake the 10 ms timer restarts.
// - non-waking accesses during powerdown complete, part stays asleep.
// - bus inputs stay live; interrupt and DMA request keep their state.
// - motor, select, write data, gate tristated; others stay driven (code tristates them in auto powerdown only, not rate-select or direct).
// - serial auto powerdown only while config bit 4 or 5 is set.
// - transmitter sleeps when holding buffer and shift register empty.
// - receiver sleeps when receive FIFO empty and awaiting start bit.
// - ring indicate change still reported while a port sleeps.
// - tx wakes on buffer write; rx wakes on receive input change.
// - parallel auto powerdown only while config bit 3 is set.
// - EPP sleeps if not enabled, or ECP mode without EPP selected.
// - ECP sleeps if not enabled, or mode register picks SPP/PS2/EPP.
// - parallel powerdown re-evaluated whenever a mode changes.
`ifndef PAP_DEFINES_VH
`define PAP_DEFINES_VH

// apb byte offsets
`define PAP_OFF_AUTO      8'h00
`define PAP_OFF_DIRECT    8'h04
`define PAP_OFF_STATUS    8'h08

// configuration bit positions (same in both config registers)
`define PAP_BIT_FDC       0
`define PAP_BIT_PAR       3
`define PAP_BIT_UART0     4
`define PAP_BIT_UART1     5
`define PAP_CFG_RESET     8'h00

// floppy register offsets seen on the host bus
`define PAP_FA_DOR        3'h2
`define PAP_FA_MSR_DSR    3'h4
`define PAP_FA_DATA       3'h5
`define PAP_MSR_IDLE      8'h80
`define PAP_DOR_NRST_BIT  2
`define PAP_DSR_RST_BIT   7

// extended control register modes
`define PAP_ECR_SPP       3'h0
`define PAP_ECR_PS2       3'h1
`define PAP_ECR_EPP       3'h4

// auto powerdown timer
`define PAP_APD_TIME_MS   10
`define PAP_CLK_MHZ       100
`define PAP_APD_CYCLES    (`PAP_APD_TIME_MS * `PAP_CLK_MHZ * 1000)
`define PAP_TMR_W         20

`endif

// >>> design/pap_ctrl.v
/*
 * Auto and direct powerdown control for the floppy controller, two
 * serial ports and the parallel port, with an APB register slave.
 * Assumes host-bus access strobes and core idle flags arrive on pclk;
 * reset, serial receive and ring indicate pins are asynchronous.
 */
`timescale 1ns/100ps
`default_nettype none
`include "pap_defines.vh"

module pap_ctrl #(
	parameter APD_CYCLES = `PAP_APD_CYCLES
) (
	// apb
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg         pready,
	output reg         pslverr,
	output reg  [31:0] prdata,
	// floppy register accesses seen on the host bus
	input  wire        host_rd_stb,
	input  wire        host_wr_stb,
	input  wire [2:0]  host_addr,
	input  wire [7:0]  host_wdata,
	// asynchronous pins
	input  wire        bus_reset_in,
	input  wire [1:0]  serial_rx_input,
	input  wire [1:0]  ring_indicate,
	// floppy core state
	input  wire [3:0]  core_motor_en,
	input  wire [7:0]  core_msr,
	input  wire        core_int,
	input  wire        core_drq,
	input  wire        head_unload_expired,
	input  wire        dsr_powerdown,
	// floppy core drive-side signals
	input  wire [1:0]  core_motor_n,
	input  wire [1:0]  core_select_n,
	input  wire        core_wdata_n,
	input  wire        core_wgate_n,
	input  wire        core_dir_n,
	input  wire        core_step_n,
	input  wire        core_head_n,
	input  wire [1:0]  core_density,
	// serial core state
	input  wire [1:0]  tx_write_stb,
	input  wire [1:0]  tx_hold_empty,
	input  wire [1:0]  tx_shift_empty,
	input  wire [1:0]  rx_fifo_empty,
	input  wire [1:0]  rx_idle,
	// parallel port configuration
	input  wire        epp_enabled,
	input  wire        ecp_enabled,
	input  wire [2:0]  ecr_mode,
	// floppy powerdown and wake
	output reg         fdc_powerdown,
	output reg         fdc_wake_resume,
	output reg         fdc_wake_reset,
	output reg         irq_out,
	output reg         drq_out,
	// drive pins
	output reg  [1:0]  motor_on_out_n,
	output reg  [1:0]  motor_on_oe,
	output reg  [1:0]  drive_select_out_n,
	output reg  [1:0]  drive_select_oe,
	output reg         write_stream_out_n,
	output reg         write_stream_oe,
	output reg         write_gate_out_n,
	output reg         write_gate_oe,
	output reg         step_direction_out_n,
	output reg         step_pulse_out_n,
	output reg         head_side_out_n,
	output reg  [1:0]  density_out,
	// serial and parallel powerdown
	output reg  [1:0]  uart_tx_pd,
	output reg  [1:0]  uart_rx_pd,
	output reg  [1:0]  ri_event,
	output reg         epp_pd,
	output reg         ecp_pd
);

	localparam integer          TMR_LAST_I = APD_CYCLES - 1;
	localparam [`PAP_TMR_W-1:0] TMR_LAST   = TMR_LAST_I[`PAP_TMR_W-1:0];

	reg  [7:0]             auto_cfg;
	reg  [7:0]             direct_cfg;
	reg  [`PAP_TMR_W-1:0]  tmr;
	reg                    tmr_done;
	reg                    fdc_auto_pd;
	reg                    dsr_pd_d;
	reg  [4:0]             sync1;
	reg  [4:0]             sync2;
	reg  [4:0]             sync3;
	reg  [4:0]             pin_level;
	wire [4:0]             pin_agree;
	wire [4:0]             pin_change;
	wire                   apb_done;
	wire                   apb_wr;
	wire                   fdc_en;
	wire                   fdc_direct;
	wire                   hw_reset_rise;
	wire                   sw_reset;
	wire                   reg_wake;
	wire                   wake_any;
	wire                   fdc_idle;
	wire                   fdc_pd_next;
	wire [1:0]             uart_en;
	wire [1:0]             uart_direct;
	wire                   par_en;
	wire                   par_direct;
	wire                   ecp_mode;
	wire                   next_epp_pd;
	wire                   next_ecp_pd;

	// apb slave: one access cycle, no wait states
	assign apb_done = psel & penable & pready;
	assign apb_wr   = apb_done & pwrite;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			prdata     <= 32'h00000000;
			auto_cfg   <= `PAP_CFG_RESET;
			direct_cfg <= `PAP_CFG_RESET;
		end
		else
		begin
			pready <= psel & ~penable & ~pready;
			// error flag stands only beside pready
			pslverr <= 1'b0;
			if (psel & ~penable)
			begin
				pslverr <= 1'b0;
				prdata  <= 32'h00000000;
				case (paddr)
					`PAP_OFF_AUTO:   prdata[7:0] <= auto_cfg;
					`PAP_OFF_DIRECT: prdata[7:0] <= direct_cfg;
					`PAP_OFF_STATUS:
						prdata[8:0] <= {tmr_done, ecp_pd, epp_pd,
						                uart_rx_pd, uart_tx_pd,
						                fdc_auto_pd, fdc_powerdown};
					default:         pslverr <= 1'b1;
				endcase
			end
			if (apb_wr && paddr == `PAP_OFF_AUTO)
				auto_cfg <= pwdata[7:0];
			if (apb_wr && paddr == `PAP_OFF_DIRECT)
				direct_cfg <= pwdata[7:0];
		end
	end

	// pins: three stages, a change counts once stages two and three agree
	assign pin_agree  = ~(sync2 ^ sync3);
	assign pin_change = pin_agree & (sync3 ^ pin_level);

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1     <= 5'h00;
			sync2     <= 5'h00;
			sync3     <= 5'h00;
			pin_level <= 5'h00;
		end
		else
		begin
			sync1     <= {bus_reset_in, ring_indicate, serial_rx_input};
			sync2     <= sync1;
			sync3     <= sync2;
			pin_level <= (pin_level & ~pin_agree) | (sync3 & pin_agree);
		end
	end

	// floppy wake decode
	assign fdc_en        = auto_cfg[`PAP_BIT_FDC];
	assign fdc_direct    = direct_cfg[`PAP_BIT_FDC];
	assign hw_reset_rise = pin_change[4] & sync3[4];
	assign sw_reset = host_wr_stb &
		((host_addr == `PAP_FA_DOR &&
		  !host_wdata[`PAP_DOR_NRST_BIT]) ||
		 (host_addr == `PAP_FA_MSR_DSR &&
		  host_wdata[`PAP_DSR_RST_BIT]));
	assign reg_wake =
		(host_wr_stb && host_addr == `PAP_FA_DOR &&
		 host_wdata[7:4] != 4'h0) ||
		(host_rd_stb && host_addr == `PAP_FA_MSR_DSR) ||
		((host_rd_stb | host_wr_stb) &&
		 host_addr == `PAP_FA_DATA);
	assign wake_any = hw_reset_rise | sw_reset | reg_wake;

	assign fdc_idle = core_motor_en == 4'h0 &&
		core_msr == `PAP_MSR_IDLE &&
		!core_int;
	assign fdc_pd_next = fdc_en & ~wake_any & ~dsr_powerdown &
		(fdc_auto_pd | (fdc_idle & head_unload_expired &
		 tmr_done));

	// floppy timer and auto powerdown state
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tmr             <= {`PAP_TMR_W{1'b0}};
			tmr_done        <= 1'b0;
			fdc_auto_pd     <= 1'b0;
			dsr_pd_d        <= 1'b0;
			fdc_powerdown   <= 1'b0;
			fdc_wake_resume <= 1'b0;
			fdc_wake_reset  <= 1'b0;
		end
		else
		begin
			dsr_pd_d <= dsr_powerdown;
			if (!fdc_en || wake_any || dsr_powerdown || dsr_pd_d)
			begin
				tmr      <= {`PAP_TMR_W{1'b0}};
				tmr_done <= 1'b0;
			end
			else if (!tmr_done)
			begin
				tmr      <= tmr + 1'b1;
				tmr_done <= tmr == TMR_LAST;
			end
			fdc_auto_pd     <= fdc_pd_next;
			fdc_powerdown   <= fdc_pd_next | dsr_powerdown | fdc_direct;
			fdc_wake_resume <= fdc_auto_pd & reg_wake &
				~hw_reset_rise & ~sw_reset;
			fdc_wake_reset  <= fdc_auto_pd &
				(hw_reset_rise | sw_reset);
		end
	end

	// drive and system pins
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_out              <= 1'b0;
			drq_out              <= 1'b0;
			motor_on_out_n       <= 2'h3;
			motor_on_oe          <= 2'h0;
			drive_select_out_n   <= 2'h3;
			drive_select_oe      <= 2'h0;
			write_stream_out_n   <= 1'b1;
			write_stream_oe      <= 1'b0;
			write_gate_out_n     <= 1'b1;
			write_gate_oe        <= 1'b0;
			step_direction_out_n <= 1'b1;
			step_pulse_out_n     <= 1'b1;
			head_side_out_n      <= 1'b1;
			density_out          <= 2'h0;
		end
		else
		begin
			irq_out              <= core_int;
			drq_out              <= core_drq;
			motor_on_out_n       <= core_motor_n;
			drive_select_out_n   <= core_select_n;
			write_stream_out_n   <= core_wdata_n;
			write_gate_out_n     <= core_wgate_n;
			motor_on_oe          <= {2{~fdc_pd_next}};
			drive_select_oe      <= {2{~fdc_pd_next}};
			write_stream_oe      <= ~fdc_pd_next;
			write_gate_oe        <= ~fdc_pd_next;
			step_direction_out_n <= core_dir_n;
			step_pulse_out_n     <= core_step_n;
			head_side_out_n      <= core_head_n;
			density_out          <= core_density;
		end
	end

	// serial ports
	assign uart_en     = {auto_cfg[`PAP_BIT_UART1],
	                      auto_cfg[`PAP_BIT_UART0]};
	assign uart_direct = {direct_cfg[`PAP_BIT_UART1],
	                      direct_cfg[`PAP_BIT_UART0]};

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			uart_tx_pd <= 2'h0;
			uart_rx_pd <= 2'h0;
			ri_event   <= 2'h0;
		end
		else
		begin
			uart_tx_pd <= uart_direct | (uart_en & ~tx_write_stb &
				(uart_tx_pd | (tx_hold_empty & tx_shift_empty)));
			uart_rx_pd <= uart_direct | (uart_en & ~pin_change[1:0] &
				(uart_rx_pd | (rx_fifo_empty & rx_idle)));
			ri_event   <= pin_change[3:2];
		end
	end

	// parallel port
	assign par_en      = auto_cfg[`PAP_BIT_PAR];
	assign par_direct  = direct_cfg[`PAP_BIT_PAR];
	assign ecp_mode    = ecp_enabled;
	assign next_epp_pd = par_direct | (par_en & (~epp_enabled |
		(ecp_mode & ecr_mode != `PAP_ECR_EPP)));
	assign next_ecp_pd = par_direct | (par_en & (~ecp_enabled |
		ecr_mode == `PAP_ECR_SPP || ecr_mode == `PAP_ECR_PS2 ||
		ecr_mode == `PAP_ECR_EPP));

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			epp_pd <= 1'b0;
			ecp_pd <= 1'b0;
		end
		else
		begin
			epp_pd <= next_epp_pd;
			ecp_pd <= next_ecp_pd & (par_en | par_direct);
		end
	end

endmodule
`default_nettype wire

// >>> tb/pap_chk_properties.sv
/*
 * Port-level checks of the powerdown controller.
 * Assumes it is bound to every pap_ctrl instance.
 */
`timescale 1ns/100ps
`default_nettype none
module pap_chk (
	// apb
	input wire logic       pclk, presetn, psel, penable, pready, pslverr,
	// host strobes and floppy state
	input wire logic       host_rd_stb, fdc_powerdown, fdc_wake_resume,
	input wire logic [2:0] host_addr,
	input wire logic       step_direction_out_n, core_dir_n,
	// drive enables and serial state
	input wire logic [1:0] motor_on_oe, tx_write_stb, uart_tx_pd,
	input wire logic [1:0] tx_hold_empty, tx_shift_empty
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_apb_zero_wait: assert property (psel && !penable |=> pready && penable)
		else $error("pready not in access cycle");
	chk_err_with_ready: assert property (pslverr |-> pready && penable)
		else $error("pslverr without pready");
	chk_dor_read_quiet: assert property (
		host_rd_stb && host_addr == 3'h2 |=> !fdc_wake_resume)
		else $error("drive output read woke block");
	chk_wake_drives_pins: assert property (
		fdc_wake_resume |-> motor_on_oe == 2'b11)
		else $error("drive pins not driven at wake");
	chk_wake_single_pulse: assert property (
		fdc_wake_resume |=> !fdc_wake_resume)
		else $error("wake pulse too long");
	chk_tx_buffer_wake: assert property (
		tx_write_stb[0] |=> !uart_tx_pd[0])
		else $error("transmitter still down after write");
	chk_tx_idle_entry: assert property (
		$rose(uart_tx_pd[0]) |-> $past(tx_hold_empty[0] && tx_shift_empty[0]))
		else $error("transmitter down while busy");
	chk_step_stays_active: assert property (
		!motor_on_oe[0] |=> step_direction_out_n == $past(core_dir_n))
		else $error("step direction not driven in powerdown");
endmodule
bind pap_ctrl pap_chk u_chk (.*);
`default_nettype wire

// >>> tb/pap_host.sv
/*
 * Host bus side: floppy register read and write strobes.
 * Assumes the caller starts each access just after a pclk edge.
 */
`timescale 1ns/100ps
`default_nettype none
module pap_host (
	input wire logic  pclk,
	output logic       host_rd_stb, host_wr_stb,
	output logic [2:0] host_addr,
	output logic [7:0] host_wdata
);
	initial {host_rd_stb, host_wr_stb, host_addr, host_wdata} = 13'h0;
	// one-cycle strobe; address and data scrambled once released
	task access(input logic r, input logic [2:0] a, input logic [7:0] d);
		host_rd_stb <= r;
		host_wr_stb <= !r;
		host_addr <= a;
		host_wdata <= d;
		@(posedge pclk);
		{host_rd_stb, host_wr_stb} <= 2'b00;
		host_addr <= ~a;
		host_wdata <= ~d;
	endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
/*
 * Self-checking bench of pap_ctrl with a host bus model.
 * Assumes a shortened powerdown timer of APD cycles.
 */
`timescale 1ns/100ps
`default_nettype none
`include "pap_defines.vh"
module tb_top;
	localparam int APD = 20;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr, core_msr, host_wdata;
	logic [31:0] pwdata, prdata, rd, rnd;
	logic host_rd_stb, host_wr_stb, bus_reset_in, core_int, core_drq;
	logic [2:0] host_addr, ecr_mode;
	logic head_unload_expired, dsr_powerdown, epp_enabled, ecp_enabled;
	logic [1:0] serial_rx_input, ring_indicate, core_motor_n, core_select_n;
	logic [1:0] core_density, tx_write_stb, tx_hold_empty, tx_shift_empty;
	logic [1:0] rx_fifo_empty, rx_idle, seen;
	logic core_wdata_n, core_wgate_n, core_dir_n, core_step_n, core_head_n;
	logic [3:0] core_motor_en;
	logic fdc_powerdown, fdc_wake_resume, fdc_wake_reset, irq_out, drq_out;
	logic [1:0] motor_on_out_n, motor_on_oe, drive_select_out_n;
	logic [1:0] drive_select_oe, density_out, uart_tx_pd, uart_rx_pd;
	logic write_stream_out_n, write_stream_oe, write_gate_out_n;
	logic write_gate_oe, step_direction_out_n, step_pulse_out_n;
	logic head_side_out_n, epp_pd, ecp_pd;
	logic [1:0] ri_event;
	logic [11:0] e;
	int miscompares, check_count, n, k;
	logic [11:0] tbl [12] = '{12'hA00, 12'h800, 12'h900, 12'hF00, 12'h755,
		12'h204, 12'h402, 12'hC00, 12'hD00, 12'h5A5, 12'h214, 12'h480};
	pap_ctrl #(.APD_CYCLES(APD)) u_pap_ctrl (.*);
	pap_host u_pap_host (.*);
	always #5 pclk = ~pclk;
	function logic [31:0] xs(input logic [31:0] s);
		xs = s ^ (s << 13);
		xs = xs ^ (xs >> 17);
		xs = xs ^ (xs << 5);
	endfunction
	// expected wake decision of a host access
	function logic wakes(input logic r, input logic [2:0] a,
		input logic [7:0] d);
		wakes = r ? (a == `PAP_FA_MSR_DSR || a == `PAP_FA_DATA)
			: (a == `PAP_FA_DATA || (a == `PAP_FA_DOR && (d[7:4] != 4'h0
			|| !d[`PAP_DOR_NRST_BIT])) || (a == `PAP_FA_MSR_DSR
			&& d[`PAP_DSR_RST_BIT]));
	endfunction
	task close_out;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] x);
		check_count++;
		if (s !== x)
		begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, x);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		{penable, pwrite, paddr, pwdata} <= {1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 9);
		if (n >= 9)
		begin
			miscompares++;
			close_out;
		end
		{rd, err} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
		@(posedge pclk);
	endtask
	task wait_pd(input logic v);
		n = 0;
		while (fdc_powerdown !== v && n++ < 200) @(posedge pclk);
		if (n > 200)
		begin
			miscompares++;
			close_out;
		end
	endtask
	initial
	begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = 0;
		{bus_reset_in, core_int, core_drq, dsr_powerdown, ecr_mode} = 0;
		{serial_rx_input, ring_indicate, tx_write_stb, rx_idle} = 8'h03;
		{core_motor_n, core_select_n, core_density, core_wdata_n} = 7'h7F;
		{core_wgate_n, core_dir_n, core_step_n, core_head_n} = 4'hF;
		{tx_hold_empty, tx_shift_empty, rx_fifo_empty} = 6'h3F;
		{core_motor_en, core_msr, head_unload_expired} = 13'h101;
		{epp_enabled, ecp_enabled, rnd} = {2'b10, 32'h6954};
		{miscompares, check_count} = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, `PAP_OFF_AUTO, 0);
		chk(rd, `PAP_CFG_RESET);
		apb(0, 8'h0C, 0);
		chk(err, 1);
		chk(rd, 0);
		repeat (40) @(posedge pclk);
		chk(fdc_powerdown, 0);
		apb(1, `PAP_OFF_AUTO, 32'h39);
		wait_pd(1);
		chk(n >= APD && n <= APD + 4, 1);
		apb(0, `PAP_OFF_STATUS, 0);
		chk(rd[7:0], 8'hBF);
		$display("end of entry test");
		for (k = 0; k < 12; k++)
		begin
			rnd = xs(rnd);
			e = tbl[k];
			if (e[10:8] == 3'h7)
				e[7:0] = rnd[31:24];
			{core_motor_n, core_select_n, core_density, core_wdata_n,
				core_wgate_n, core_dir_n, core_step_n, core_head_n} <= rnd[10:0];
			wait_pd(1);
			u_pap_host.access(e[11], e[10:8], e[7:0]);
			@(negedge pclk);
			chk(fdc_powerdown, !wakes(e[11], e[10:8], e[7:0]));
			chk(motor_on_oe, wakes(e[11], e[10:8], e[7:0]) ? 3 : 0);
			chk({motor_on_out_n, drive_select_out_n, density_out,
				write_stream_out_n, write_gate_out_n, step_direction_out_n,
				step_pulse_out_n, head_side_out_n}, rnd[10:0]);
			chk({irq_out, drq_out}, 0);
			@(posedge pclk);
		end
		for (k = 0; k < 4; k++)
		begin
			wait_pd(1);
			u_pap_host.access(1, `PAP_FA_MSR_DSR, 0);
			case (k)
				0: core_int <= 1'b1;
				1: core_msr <= 8'h81;
				2: core_motor_en <= 4'h1;
				default: head_unload_expired <= 1'b0;
			endcase
			repeat (3 * APD) @(posedge pclk);
			chk(fdc_powerdown, 0);
			{core_int, core_msr, core_motor_en, head_unload_expired} <= 14'h1001;
		end
		wait_pd(1);
		bus_reset_in <= 1'b1;
		wait_pd(0);
		bus_reset_in <= 1'b0;
		wait_pd(1);
		apb(1, `PAP_OFF_AUTO, 32'h38);
		repeat (40) @(posedge pclk);
		chk(fdc_powerdown, 0);
		dsr_powerdown <= 1'b1;
		repeat (2) @(posedge pclk);
		chk(fdc_powerdown, 1);
		dsr_powerdown <= 1'b0;
		apb(1, `PAP_OFF_DIRECT, 32'h1);
		@(negedge pclk);
		chk(fdc_powerdown, 1);
		@(posedge pclk);
		apb(1, `PAP_OFF_DIRECT, 32'h0);
		$display("end of floppy tests");
		tx_hold_empty <= 2'b10;
		tx_write_stb <= 2'b01;
		@(posedge pclk);
		tx_write_stb <= 2'b00;
		@(negedge pclk);
		chk(uart_tx_pd, 2'b10);
		rx_idle <= 2'b10;
		serial_rx_input <= 2'b01;
		ring_indicate <= 2'b10;
		seen = 0;
		repeat (8) @(posedge pclk) seen |= ri_event;
		chk({seen, uart_rx_pd}, 4'hA);
		$display("end of serial tests");
		ecp_enabled <= 1'b1;
		for (k = 0; k < 8; k++)
		begin
			rnd = xs(rnd);
			ecr_mode <= rnd[2:0];
			repeat (2) @(posedge pclk);
			chk({ecp_pd, epp_pd}, {rnd[2:0] inside {`PAP_ECR_SPP, `PAP_ECR_PS2,
				`PAP_ECR_EPP}, rnd[2:0] != `PAP_ECR_EPP});
		end
		apb(1, `PAP_OFF_AUTO, 0);
		repeat (2) @(posedge pclk);
		chk({ecp_pd, epp_pd}, 0);
		$display("end of parallel tests");
		close_out;
	end
endmodule
`default_nettype wire
